// >>> core/gdp_pkg.sv
// package: constants and carriers for the pwm gate drive configuration block
//
// Summary of operation
// - adaptive scheme regulates pre-currents toward delay targets
// - scheme zero skips pre-charge and pre-discharge
// - scheme one drives fixed initial pre-currents
// - scheme applies to detected or pwm mosfet
// - free-wheeling needs afw, pwm enable, three-input mode
// - free-wheel bit inserts cross-current protection time
// - with active free-wheeling enabled, active mosfet off turns opposite one on
// - post-charge ramps one step per driver tick
// - post-charge disabled holds configured charge current
// - pre-currents limited to bridge maximum current
// - adaptive pre-charge clamped lowest code to maximum
// - adaptive pre-discharge clamped lowest code to maximum
// - adaptive currents seeded from initial values
// - hard-off sink uses full-scale code 63
// - pre-phase durations timed from programmed values
// - charge, discharge, free-wheel currents from bridge config
// - hold current chosen by hold select bit
// - hold codes 15 or 20 by select
// - detection off treats pwm mosfet as active
package gdp_pkg;
   localparam int CUR_W = 6;
   localparam int TIM_W = 8;
   localparam logic [CUR_W-1:0] CUR_LOWEST = 6'h00;
   localparam logic [CUR_W-1:0] CUR_HARD_OFF = 6'h3F;  // decimal 63
   localparam logic [CUR_W-1:0] CUR_HOLD_LO = 6'h0F;   // decimal 15
   localparam logic [CUR_W-1:0] CUR_HOLD_HI = 6'h14;   // decimal 20
   localparam logic [1:0] SCHEME_OFF = 2'h0;
   localparam logic [1:0] SCHEME_FIXED = 2'h1;
   localparam int BDCLK_DIV_DEF = 16;                 // mclk cycles per bridge driver tick

   // per-bridge configuration, static while the bridge runs
   typedef struct packed {
      logic bridge_pwm_en;
      logic active_freewheel_sel;
      logic pwm_hs_sel;                          // 1: pwm drives high side
      logic [TIM_W-1:0] precharge_time;          // mclk cycles
      logic [TIM_W-1:0] predischarge_time;
      logic [TIM_W-1:0] active_crossprot_time;
      logic [TIM_W-1:0] active_blank_time;
      logic [TIM_W-1:0] turn_on_target;
      logic [TIM_W-1:0] turn_off_target;
      logic [CUR_W-1:0] active_charge_current;
      logic [CUR_W-1:0] active_discharge_current;
      logic [CUR_W-1:0] freewheel_current;
      logic [CUR_W-1:0] max_drive_current;
      logic [CUR_W-1:0] precharge_init_current;
      logic [CUR_W-1:0] predischarge_init_current;
   } gdp_bridge_cfg_s;

   // one gate driver command: direction and current code
   typedef struct packed {
      logic source;                              // 1 sources (charge), 0 sinks
      logic [CUR_W-1:0] code;
   } gdp_gate_cmd_s;

   typedef enum logic [2:0] {
      PH_OFF, PH_XPROT, PH_PRECHG, PH_CHARGE, PH_POST, PH_PREDCHG, PH_DISCHG
   } gdp_phase_e;
endpackage

// >>> core/gdp_gate_drive.sv
// module: pwm-mode gate current sequencing for a set of half-bridges
`timescale 1ns/10ps
module gdp_gate_drive
   import gdp_pkg::*;
#(
   parameter int NB = 3,                                // half-bridges
   parameter int BDCLK_DIV = BDCLK_DIV_DEF              // bridge driver tick divider
)
(
   input wire logic mclk,                               // 250 MHz clock
   input wire logic reset,                              // async, active high
   input wire logic [1:0] gate_ctrl_scheme,             // pre-phase scheme
   input wire logic active_detect_en,                   // active/fw detection on
   input wire logic pwm_input_count_sel,                // 0: three inputs
   input wire logic postcharge_disable,                 // 1: no post-charge ramp
   input wire logic hold_current_sel,                   // hold code select
   input wire gdp_bridge_cfg_s [NB-1:0] bridge_cfg,     // per-bridge settings
   input wire logic [NB-1:0] pwm_pin,                   // pwm inputs, async
   input wire logic [NB-1:0] ls_active_pin,             // 1: low side is active, async
   input wire logic [NB-1:0] gate_on_pin,               // active switched on, async
   input wire logic [NB-1:0] gate_off_pin,              // active switched off, async
   output gdp_gate_cmd_s [NB-1:0] hs_gate,              // high-side gate command
   output gdp_gate_cmd_s [NB-1:0] ls_gate,              // low-side gate command
   output logic [NB-1:0] freewheel_active,              // active free-wheeling enabled
   output logic [NB-1:0][CUR_W-1:0] precharge_current,  // live pre-charge code
   output logic [NB-1:0][CUR_W-1:0] predischarge_current, // live pre-discharge code
   output logic [NB-1:0][TIM_W-1:0] turn_on_delay,      // last measured on delay
   output logic [NB-1:0][TIM_W-1:0] turn_off_delay      // last measured off delay
);
   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (NB < 1 || BDCLK_DIV < 2 || BDCLK_DIV > 65536)
   begin : g_bad
      $error("gdp_gate_drive: unsupported NB or BDCLK_DIV");
   end

   // ----------------------------------------------------------------
   // bridge driver clock tick, shared by all bridges
   // ----------------------------------------------------------------
   logic [15:0] bd_cnt_q, bd_cnt_d;
   logic bd_tick_q, bd_tick_d;

   // free-running divider; tick paces the post-charge ramp
   always_comb
   begin
      bd_tick_d = (bd_cnt_q == 16'(BDCLK_DIV - 1));
      bd_cnt_d = bd_tick_d ? 16'h0000 : bd_cnt_q + 16'h0001;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         bd_cnt_q <= 16'h0000;
         bd_tick_q <= 1'b0;
      end
      else
      begin
         bd_cnt_q <= bd_cnt_d;
         bd_tick_q <= bd_tick_d;
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers: pwm, detection and gate comparators
   // ----------------------------------------------------------------
   logic [3:0][NB-1:0] sync1_q, sync2_q;

   // first stage feeds only the second; all logic reads sync2_q
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= {gate_off_pin, gate_on_pin, ls_active_pin, pwm_pin};
         sync2_q <= sync1_q;
      end
   end

   // ----------------------------------------------------------------
   // per-bridge sequencer
   // ----------------------------------------------------------------
   for (genvar b = 0; b < NB; b++)
   begin : g_hb
      gdp_bridge_cfg_s cfg;
      logic pwm_s, ls_act_s, on_s, off_s;
      logic afw_on, pre_on, adaptive;
      logic [CUR_W-1:0] hold_code, pchg_use, pdchg_use;
      gdp_phase_e ph_q, ph_d;
      logic [TIM_W-1:0] cnt_q, cnt_d, meas_q, meas_d, ton_q, ton_d, toff_q, toff_d;
      logic pwm_prev_q, act_hs_q, act_hs_d, meas_run_q, meas_run_d, seeded_q;
      logic [CUR_W-1:0] ramp_q, ramp_d, apc_q, apc_d, apd_q, apd_d;
      gdp_gate_cmd_s act_cmd, opp_cmd, hs_q, hs_d, ls_q, ls_d;
      logic afw_q;

      assign cfg = bridge_cfg[b];
      assign pwm_s = sync2_q[0][b];
      assign ls_act_s = sync2_q[1][b];
      assign on_s = sync2_q[2][b];
      assign off_s = sync2_q[3][b];

      // free-wheeling only in three-input pwm with both bits set
      assign afw_on = cfg.active_freewheel_sel & cfg.bridge_pwm_en & ~pwm_input_count_sel;
      assign pre_on = (gate_ctrl_scheme != SCHEME_OFF);
      assign adaptive = gate_ctrl_scheme[1];
      assign hold_code = hold_current_sel ? CUR_HOLD_HI : CUR_HOLD_LO;

      // pre-currents: fixed scheme uses initial values, always capped at maximum
      always_comb
      begin
         pchg_use = adaptive ? apc_q : cfg.precharge_init_current;
         pdchg_use = adaptive ? apd_q : cfg.predischarge_init_current;
         if (pchg_use > cfg.max_drive_current)
            pchg_use = cfg.max_drive_current;
         if (pdchg_use > cfg.max_drive_current)
            pdchg_use = cfg.max_drive_current;
      end

      // phase sequencing; cnt_q times the protect, pre-phase, blank and discharge windows in mclk cycles
      always_comb
      begin
         ph_d = ph_q;
         cnt_d = (cnt_q != '0) ? cnt_q - TIM_W'(1) : cnt_q;
         act_hs_d = act_hs_q;
         ramp_d = ramp_q;
         if (!cfg.bridge_pwm_en)
            ph_d = PH_OFF;
         else
         begin
            unique case (ph_q)
               PH_OFF:
                  if (pwm_s && !pwm_prev_q)
                  begin
                     // latch which mosfet the pre-phases act on
                     act_hs_d = active_detect_en ? ~ls_act_s : cfg.pwm_hs_sel;
                     if (cfg.active_freewheel_sel)
                     begin
                        ph_d = PH_XPROT;
                        cnt_d = cfg.active_crossprot_time;
                     end
                     else if (pre_on)
                     begin
                        ph_d = PH_PRECHG;
                        cnt_d = cfg.precharge_time;
                     end
                     else
                     begin
                        ph_d = PH_CHARGE;
                        cnt_d = cfg.active_blank_time;
                     end
                  end
               PH_XPROT:
                  if (cnt_q == '0)
                  begin
                     ph_d = pre_on ? PH_PRECHG : PH_CHARGE;
                     cnt_d = pre_on ? cfg.precharge_time : cfg.active_blank_time;
                  end
               PH_PRECHG:
                  if (cnt_q == '0)
                  begin
                     ph_d = PH_CHARGE;
                     cnt_d = cfg.active_blank_time;
                  end
               PH_CHARGE:
                  if (cnt_q == '0 && !postcharge_disable)
                  begin
                     ph_d = PH_POST;
                     ramp_d = cfg.active_charge_current;
                  end
               PH_POST:
                  if (bd_tick_q && ramp_q < cfg.max_drive_current)
                     ramp_d = ramp_q + CUR_W'(1);
               PH_PREDCHG:
                  if (cnt_q == '0)
                  begin
                     ph_d = PH_DISCHG;
                     cnt_d = cfg.active_crossprot_time;
                  end
               PH_DISCHG:
                  if (cnt_q == '0)
                     ph_d = PH_OFF;
               default:
                  ph_d = PH_OFF;
            endcase
            // falling pwm ends any on phase
            if (!pwm_s && pwm_prev_q && ph_q != PH_OFF && ph_q != PH_PREDCHG && ph_q != PH_DISCHG)
            begin
               ph_d = pre_on ? PH_PREDCHG : PH_DISCHG;
               cnt_d = pre_on ? cfg.predischarge_time : cfg.active_crossprot_time;
            end
         end
      end

      // delay measurement and adaptation of the pre-currents
      always_comb
      begin
         meas_run_d = meas_run_q;
         meas_d = (meas_run_q && meas_q != '1) ? meas_q + TIM_W'(1) : meas_q;
         ton_d = ton_q;
         toff_d = toff_q;
         apc_d = apc_q;
         apd_d = apd_q;
         if (!seeded_q || !adaptive)
         begin
            apc_d = cfg.precharge_init_current;
            apd_d = cfg.predischarge_init_current;
         end
         if (ph_d != ph_q && (ph_d == PH_PRECHG || ph_d == PH_PREDCHG ||
             (ph_q == PH_XPROT && ph_d == PH_CHARGE) || (ph_q == PH_OFF && ph_d == PH_CHARGE) ||
             (ph_d == PH_DISCHG && ph_q != PH_PREDCHG)))
         begin
            meas_run_d = 1'b1;
            meas_d = '0;
         end
         else if (meas_run_q && (ph_q == PH_PRECHG || ph_q == PH_CHARGE || ph_q == PH_POST) && on_s)
         begin
            meas_run_d = 1'b0;
            ton_d = meas_q;
            // late turn-on wants more pre-charge, early wants less
            if (adaptive && seeded_q)
            begin
               if (meas_q > cfg.turn_on_target && apc_q < cfg.max_drive_current)
                  apc_d = apc_q + CUR_W'(1);
               else if (meas_q < cfg.turn_on_target && apc_q > CUR_LOWEST)
                  apc_d = apc_q - CUR_W'(1);
            end
         end
         else if (meas_run_q && (ph_q == PH_PREDCHG || ph_q == PH_DISCHG) && off_s)
         begin
            meas_run_d = 1'b0;
            toff_d = meas_q;
            if (adaptive && seeded_q)
            begin
               if (meas_q > cfg.turn_off_target && apd_q < cfg.max_drive_current)
                  apd_d = apd_q + CUR_W'(1);
               else if (meas_q < cfg.turn_off_target && apd_q > CUR_LOWEST)
                  apd_d = apd_q - CUR_W'(1);
            end
         end
         // last clamp also catches seeds above the maximum
         if (apc_d > cfg.max_drive_current)
            apc_d = cfg.max_drive_current;
         if (apd_d > cfg.max_drive_current)
            apd_d = cfg.max_drive_current;
      end

      // gate currents for the active and the opposite mosfet per phase
      always_comb
      begin
         act_cmd = '{source: 1'b0, code: hold_code};
         opp_cmd = '{source: 1'b0, code: CUR_HARD_OFF};
         unique case (ph_q)
            PH_OFF:
               if (afw_on)
                  opp_cmd = '{source: 1'b1, code: cfg.freewheel_current};
               else
                  opp_cmd = '{source: 1'b0, code: hold_code};
            PH_XPROT:
               opp_cmd = '{source: 1'b0, code: cfg.freewheel_current};
            PH_PRECHG:
               act_cmd = '{source: 1'b1, code: pchg_use};
            PH_CHARGE:
               act_cmd = '{source: 1'b1, code: cfg.active_charge_current};
            PH_POST:
               act_cmd = '{source: 1'b1, code: ramp_q};
            PH_PREDCHG:
               act_cmd = '{source: 1'b0, code: pdchg_use};
            PH_DISCHG:
               act_cmd = '{source: 1'b0, code: cfg.active_discharge_current};
            default:
               act_cmd = '{source: 1'b0, code: hold_code};
         endcase
         if (!cfg.bridge_pwm_en)
            opp_cmd = '{source: 1'b0, code: hold_code};
         hs_d = act_hs_q ? act_cmd : opp_cmd;
         ls_d = act_hs_q ? opp_cmd : act_cmd;
      end

      // state registers of this bridge
      always_ff @(posedge mclk or posedge reset)
      begin
         if (reset)
         begin
            ph_q <= PH_OFF;
            cnt_q <= '0;
            meas_q <= '0;
            meas_run_q <= 1'b0;
            ton_q <= '0;
            toff_q <= '0;
            pwm_prev_q <= 1'b0;
            act_hs_q <= 1'b1;
            ramp_q <= CUR_LOWEST;
            apc_q <= CUR_LOWEST;
            apd_q <= CUR_LOWEST;
            seeded_q <= 1'b0;
            hs_q <= '{source: 1'b0, code: CUR_HOLD_LO};
            ls_q <= '{source: 1'b0, code: CUR_HOLD_LO};
            afw_q <= 1'b0;
         end
         else
         begin
            ph_q <= ph_d;
            cnt_q <= cnt_d;
            meas_q <= meas_d;
            meas_run_q <= meas_run_d;
            ton_q <= ton_d;
            toff_q <= toff_d;
            pwm_prev_q <= pwm_s;
            act_hs_q <= act_hs_d;
            ramp_q <= ramp_d;
            apc_q <= apc_d;
            apd_q <= apd_d;
            seeded_q <= 1'b1;        // seeding from ports happens one cycle after release
            hs_q <= hs_d;
            ls_q <= ls_d;
            afw_q <= afw_on;
         end
      end

      assign hs_gate[b] = hs_q;
      assign ls_gate[b] = ls_q;
      assign freewheel_active[b] = afw_q;
      assign precharge_current[b] = apc_q;
      assign predischarge_current[b] = apd_q;
      assign turn_on_delay[b] = ton_q;
      assign turn_off_delay[b] = toff_q;
   end
endmodule

// >>> tb/gdp_gate_drive_assertions.sv
// checker: port-level properties of the gate drive block
`timescale 1ns/10ps
module gdp_gate_drive_checker
   import gdp_pkg::*;
#(
   parameter int NB = 3 // half-bridges
)
(
   input wire logic mclk, // clock
   input wire logic reset, // async reset
   input wire logic [1:0] gate_ctrl_scheme, // scheme
   input wire logic pwm_input_count_sel, // input count
   input wire logic postcharge_disable, // ramp off
   input wire logic hold_current_sel, // hold select
   input wire gdp_bridge_cfg_s [NB-1:0] bridge_cfg, // settings
   input wire gdp_gate_cmd_s [NB-1:0] hs_gate, // high side
   input wire gdp_gate_cmd_s [NB-1:0] ls_gate, // low side
   input wire logic [NB-1:0] freewheel_active, // fw on
   input wire logic [NB-1:0][CUR_W-1:0] precharge_current, // pre-charge code
   input wire logic [NB-1:0][CUR_W-1:0] predischarge_current // pre-discharge code
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   gdp_bridge_cfg_s c0;
   logic hs_drv;
   logic fw_in;
   // bridge 0 only: high side driven on while low side is hard off
   assign c0 = bridge_cfg[0];
   assign hs_drv = hs_gate[0].source && ls_gate[0] == {1'b0, CUR_HARD_OFF};
   assign fw_in = c0.active_freewheel_sel && c0.bridge_pwm_en && !pwm_input_count_sel;
   a_fw_enable: assert property ($stable(fw_in) [*2] |-> freewheel_active[0] == fw_in)
      else $error("free-wheel enable wrong");
   a_hard_off_opp: assert property (hs_gate[0].source && !c0.active_freewheel_sel
      |-> ls_gate[0] == {1'b0, CUR_HARD_OFF}) else $error("opposite gate not hard off");
   a_hold_idle: assert property ((!c0.bridge_pwm_en && $stable(hold_current_sel)) [*3]
      |-> hs_gate[0] == {1'b0, hold_current_sel ? CUR_HOLD_HI : CUR_HOLD_LO} && ls_gate[0] == hs_gate[0])
      else $error("idle hold code wrong");
   a_charge_fixed: assert property (hs_drv && gate_ctrl_scheme == SCHEME_OFF && postcharge_disable
      |-> hs_gate[0].code == c0.active_charge_current) else $error("charge code not held");
   a_ramp_step: assert property (hs_drv && $past(hs_drv) && hs_gate[0].code != $past(hs_gate[0].code)
      && gate_ctrl_scheme == SCHEME_OFF |-> hs_gate[0].code == $past(hs_gate[0].code) + 6'h01)
      else $error("post-charge step not one");
   a_ramp_cap: assert property (hs_drv && !postcharge_disable && gate_ctrl_scheme == SCHEME_OFF
      |-> hs_gate[0].code <= c0.max_drive_current) else $error("post-charge above max");
   a_fixed_prechg: assert property (gate_ctrl_scheme == SCHEME_FIXED && hs_drv && !$past(hs_gate[0].source)
      |-> hs_gate[0].code == ((c0.precharge_init_current > c0.max_drive_current) ? c0.max_drive_current
      : c0.precharge_init_current)) else $error("fixed pre-charge code wrong");
   a_prechg_clamp: assert property (gate_ctrl_scheme[1] |-> precharge_current[0] <= c0.max_drive_current)
      else $error("pre-charge above max");
   a_predchg_clamp: assert property (gate_ctrl_scheme[1] |-> predischarge_current[0] <= c0.max_drive_current)
      else $error("pre-discharge above max");
endmodule

bind gdp_gate_drive gdp_gate_drive_checker #(.NB(NB)) u_gdp_chk
(
   .mclk(mclk), .reset(reset), .gate_ctrl_scheme(gate_ctrl_scheme), .pwm_input_count_sel(pwm_input_count_sel),
   .postcharge_disable(postcharge_disable), .hold_current_sel(hold_current_sel), .bridge_cfg(bridge_cfg),
   .hs_gate(hs_gate), .ls_gate(ls_gate), .freewheel_active(freewheel_active),
   .precharge_current(precharge_current), .predischarge_current(predischarge_current)
);

// >>> tb/gdp_mosfet_model.sv
// partner: behavioural external half-bridge mosfets
`timescale 1ns/10ps
module gdp_mosfet_model
   import gdp_pkg::*;
#(
   parameter int NB = 3, // half-bridges
   parameter int DLY = 3 // gate threshold lag, cycles
)
(
   input wire logic mclk, // clock
   input wire logic reset, // async reset
   input wire logic [NB-1:0] ls_is_active, // load current direction
   input wire gdp_gate_cmd_s [NB-1:0] hs_gate, // high side
   input wire gdp_gate_cmd_s [NB-1:0] ls_gate, // low side
   output logic [NB-1:0] ls_active_pin, // switch node comparator
   output logic [NB-1:0] gate_on_pin, // active gate above threshold
   output logic [NB-1:0] gate_off_pin // active gate below threshold
);
   logic [NB-1:0][DLY-1:0] sh_q;
   // gate voltage lags the drive current, so the device sees a real delay
   always_ff @(posedge mclk or posedge reset)
   begin
      for (int b = 0; b < NB; b++)
      begin
         if (reset)
            sh_q[b] <= '0;
         else
            sh_q[b] <= {sh_q[b][DLY-2:0], ls_is_active[b] ? ls_gate[b].source : hs_gate[b].source};
      end
   end
   // comparators report the last stage, never both at once
   always_comb
   begin
      ls_active_pin = ls_is_active;
      for (int b = 0; b < NB; b++)
      begin
         gate_on_pin[b] = sh_q[b][DLY-1];
         gate_off_pin[b] = !sh_q[b][DLY-1];
      end
   end
endmodule

// >>> tb/gdp_gate_drive_test.sv
// testbench: directed scenarios for the gate drive block
`timescale 1ns/10ps
module gdp_gate_drive_test
   import gdp_pkg::*;
;
   logic mclk, reset, active_detect_en, pwm_input_count_sel, postcharge_disable, hold_current_sel;
   logic [1:0] gate_ctrl_scheme;
   gdp_bridge_cfg_s [0:0] bridge_cfg;
   logic [0:0] pwm_pin, ls_is_active, ls_active_pin, gate_on_pin, gate_off_pin, freewheel_active;
   gdp_gate_cmd_s [0:0] hs_gate, ls_gate;
   logic [0:0][CUR_W-1:0] precharge_current, predischarge_current;
   logic [0:0][TIM_W-1:0] turn_on_delay, turn_off_delay;
   int fails, total_checks;
   gdp_gate_drive #(.NB(1), .BDCLK_DIV(2)) uut
   (
      .mclk(mclk), .reset(reset), .gate_ctrl_scheme(gate_ctrl_scheme), .active_detect_en(active_detect_en),
      .pwm_input_count_sel(pwm_input_count_sel), .postcharge_disable(postcharge_disable),
      .hold_current_sel(hold_current_sel), .bridge_cfg(bridge_cfg), .pwm_pin(pwm_pin),
      .ls_active_pin(ls_active_pin), .gate_on_pin(gate_on_pin), .gate_off_pin(gate_off_pin),
      .hs_gate(hs_gate), .ls_gate(ls_gate), .freewheel_active(freewheel_active),
      .precharge_current(precharge_current), .predischarge_current(predischarge_current),
      .turn_on_delay(turn_on_delay), .turn_off_delay(turn_off_delay)
   );
   gdp_mosfet_model #(.NB(1), .DLY(3)) u_fets
   (
      .mclk(mclk), .reset(reset), .ls_is_active(ls_is_active), .hs_gate(hs_gate), .ls_gate(ls_gate),
      .ls_active_pin(ls_active_pin), .gate_on_pin(gate_on_pin), .gate_off_pin(gate_off_pin)
   );
   // free-running 250 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // sample a little after the edge so registered outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic set_pwm(input logic v);
      @(posedge mclk);
      pwm_pin[0] <= v;
   endtask
   task automatic set_mode(input logic [1:0] s, input logic pd, input logic afw);
      @(posedge mclk);
      gate_ctrl_scheme <= s;
      postcharge_disable <= pd;
      bridge_cfg[0].active_freewheel_sel <= afw;
      tick(4);
   endtask
   task automatic t_reset_hold();
      chk("pre seed", precharge_current[0], 32'h0000_0004);
      chk("pre-dis seed", predischarge_current[0], 32'h0000_0003);
      chk("hold lo", hs_gate[0], {1'b0, CUR_HOLD_LO});
      @(posedge mclk);
      hold_current_sel <= 1'b1;
      tick(4);
      chk("hold hi", ls_gate[0], {1'b0, CUR_HOLD_HI});
      @(posedge mclk);
      hold_current_sel <= 1'b0;
   endtask
   task automatic t_fw_table();
      for (int k = 0; k < 8; k++)
      begin
         @(posedge mclk);
         bridge_cfg[0].active_freewheel_sel <= k[0];
         bridge_cfg[0].bridge_pwm_en <= k[1];
         pwm_input_count_sel <= k[2];
         tick(3);
         chk("fw enable", freewheel_active[0], k[0] & k[1] & !k[2]);
      end
      @(posedge mclk);
      pwm_input_count_sel <= 1'b0;
      bridge_cfg[0].bridge_pwm_en <= 1'b1;
   endtask
   // scheme 0, no ramp: straight to charge and discharge currents
   task automatic t_plain();
      set_mode(SCHEME_OFF, 1'b1, 1'b0);
      set_pwm(1'b1);
      tick(5);
      chk("charge", hs_gate[0], {1'b1, 6'h02});
      chk("hard off", ls_gate[0], {1'b0, CUR_HARD_OFF});
      tick(40);
      chk("charge held", hs_gate[0], {1'b1, 6'h02});
      set_pwm(1'b0);
      tick(5);
      chk("discharge", hs_gate[0], {1'b0, 6'h0C});
      tick(30);
      chk("off hold", hs_gate[0], {1'b0, CUR_HOLD_LO});
   endtask
   // fixed pre-currents, initial pre-charge above the bridge maximum
   task automatic t_fixed();
      @(posedge mclk);
      bridge_cfg[0].precharge_init_current <= 6'h09;
      set_mode(SCHEME_FIXED, 1'b1, 1'b0);
      set_pwm(1'b1);
      tick(5);
      chk("pre-charge capped", hs_gate[0], {1'b1, 6'h07});
      tick(11);
      chk("after pre-charge", hs_gate[0], {1'b1, 6'h02});
      set_pwm(1'b0);
      tick(5);
      chk("pre-discharge", hs_gate[0], {1'b0, 6'h03});
      tick(40);
      @(posedge mclk);
      bridge_cfg[0].precharge_init_current <= 6'h04;
   endtask
   task automatic t_post();
      set_mode(SCHEME_OFF, 1'b0, 1'b0);
      set_pwm(1'b1);
      tick(60);
      chk("ramp top", hs_gate[0], {1'b1, 6'h07});
      tick(20);
      chk("ramp saturated", hs_gate[0], {1'b1, 6'h07});
      set_pwm(1'b0);
      tick(40);
   endtask
   task automatic t_freewheel();
      set_mode(SCHEME_OFF, 1'b1, 1'b1);
      chk("fw on in off", ls_gate[0], {1'b1, 6'h09});
      set_pwm(1'b1);
      tick(5);
      chk("cross protect", ls_gate[0], {1'b0, 6'h09});
      tick(30);
      chk("charge after protect", hs_gate[0], {1'b1, 6'h02});
      set_pwm(1'b0);
      tick(40);
      chk("fw on again", ls_gate[0], {1'b1, 6'h09});
      @(posedge mclk);
      pwm_input_count_sel <= 1'b1;
      tick(4);
      chk("fw blocked", ls_gate[0], {1'b0, CUR_HOLD_LO});
      @(posedge mclk);
      pwm_input_count_sel <= 1'b0;
   endtask
   task automatic t_detect();
      set_mode(SCHEME_OFF, 1'b1, 1'b0);
      for (int d = 1; d >= 0; d--)
      begin
         @(posedge mclk);
         active_detect_en <= d[0];
         ls_is_active[0] <= 1'b1;
         tick(4);
         set_pwm(1'b1);
         tick(5);
         chk("active choice", d ? ls_gate[0] : hs_gate[0], {1'b1, 6'h02});
         chk("opposite hard off", d ? hs_gate[0] : ls_gate[0], {1'b0, CUR_HARD_OFF});
         set_pwm(1'b0);
         tick(40);
      end
      @(posedge mclk);
      ls_is_active[0] <= 1'b0;
   endtask
   task automatic t_adaptive();
      set_mode(2'h2, 1'b1, 1'b0);
      repeat (9)
      begin
         set_pwm(1'b1);
         tick(60);
         set_pwm(1'b0);
         tick(60);
      end
      chk("pre-charge at max", precharge_current[0], 32'h0000_0007);
      chk("pre-discharge at min", predischarge_current[0], 32'h0000_0000);
      chk("on delay measured", turn_on_delay[0] != 8'h00, 32'h0000_0001);
      chk("off delay measured", turn_off_delay[0] != 8'h00, 32'h0000_0001);
   endtask
   task automatic complete_run();
      if (fails == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // main sequence; pre-phase times kept below blank and protect windows
   initial
   begin
      {reset, pwm_pin, ls_is_active, active_detect_en, pwm_input_count_sel} = 5'b1_0000;
      {postcharge_disable, hold_current_sel, gate_ctrl_scheme} = 4'h0;
      bridge_cfg = '0;
      bridge_cfg[0].pwm_hs_sel = 1'b1;
      bridge_cfg[0].precharge_time = 8'h0A;
      bridge_cfg[0].predischarge_time = 8'h0A;
      bridge_cfg[0].active_crossprot_time = 8'h14;
      bridge_cfg[0].active_blank_time = 8'h14;
      bridge_cfg[0].turn_off_target = 8'hFF;
      bridge_cfg[0].active_charge_current = 6'h02;
      bridge_cfg[0].active_discharge_current = 6'h0C;
      bridge_cfg[0].freewheel_current = 6'h09;
      bridge_cfg[0].max_drive_current = 6'h07;
      bridge_cfg[0].precharge_init_current = 6'h04;
      bridge_cfg[0].predischarge_init_current = 6'h03;
      fails = 0;
      total_checks = 0;
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      tick(6);
      t_reset_hold();
      t_fw_table();
      t_plain();
      t_fixed();
      t_post();
      t_freewheel();
      t_detect();
      t_adaptive();
      complete_run();
   end
   // watchdog well beyond the roughly 1640 cycles the sequence needs
   initial
   begin
      #80000;
      fails++;
      complete_run();
   end
endmodule
